// ---- bsr_bank.sv ----
/*
 Second special function register bank with its common registers,
 reached over APB3 (one wait state per transfer).
 Assumes: the core drives indirect read data combinationally from the
 pointer outputs, and peripheral status inputs share clk_sys; reset
 cause pins are asynchronous and are synchronised here.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bsr_bank
#(
   parameter int P_ADDR_W = 11
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [P_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   // Reset cause pins, asynchronous.
   input wire logic power_on_pin,
   input wire logic brown_out_pin,
   input wire logic watchdog_pin,
   input wire logic sleep_pin,
   // Peripheral status, same clock.
   input wire logic [1:0] psp_buffer_flags,
   input wire logic tx_shift_empty,
   input wire logic [5:0] serial_state,
   // Indirect data path to the core.
   input wire logic [7:0] indirect_rdata,
   output logic indirect_we,
   output logic [8:0] indirect_waddr,
   output logic [7:0] indirect_wdata,
   // Register contents towards the core and peripherals.
   output logic [12:0] program_counter,
   output logic [7:0] core_status_flags,
   output logic [7:0] indirect_address_pointer,
   output logic [7:0] core_interrupt_control,
   output logic [7:0] timer_prescale_options,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction,
   output logic [7:0] port_d_direction,
   output logic [7:0] port_e_direction,
   output logic [7:0] peripheral_int_enable_1,
   output logic [7:0] peripheral_int_enable_2,
   output logic [7:0] reset_cause_flags,
   output logic [7:0] timer2_period,
   output logic [7:0] serial_port_slave_address,
   output logic [7:0] transmitter_control,
   output logic [7:0] baud_rate_divisor,
   output logic [7:0] analog_pin_config
);
   import bsr_pkg::*;

   if (P_ADDR_W < 11)
   begin : g_chk
      $error("bsr_bank needs at least 11 address bits");
   end

   ////////////////////////////////////////////////////////////////////
   // Decode helpers.

   function automatic logic is_common(input logic [6:0] off);
      is_common = (off == OFS_INDIRECT_DATA_PORT[6:0]) ||
                  (off == OFS_PROGRAM_COUNTER_LOW[6:0]) ||
                  (off == OFS_CORE_STATUS_FLAGS[6:0]) ||
                  (off == OFS_INDIRECT_ADDRESS_POINTER[6:0]) ||
                  (off == OFS_PROGRAM_COUNTER_HIGH_LATCH[6:0]) ||
                  (off == OFS_CORE_INTERRUPT_CONTROL[6:0]);
   endfunction

   // Returns {hit, bank-one index} for an APB register index.
   function automatic logic [8:0] resolve(input logic [8:0] idx,
                                          input logic [1:0] rp);
      logic [6:0] off;
      off = idx[6:0];
      resolve = 9'h000;
      if (idx[IDX_DIRECT_BIT])
      begin
         if (rp == BANK_ONE)
            resolve = {1'b1, 1'b1, off};
         else if ((rp == BANK_ZERO) && is_common(off))
            resolve = {1'b1, 1'b1, off};
      end
      else if (idx[7])
         resolve = {1'b1, idx[7:0]};
      else if (is_common(off))
         resolve = {1'b1, 1'b1, off};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Reset cause synchroniser.

   logic [3:0] cause_s1_q;
   logic [3:0] cause_s2_q;

   always_ff @(posedge clk_sys)
   begin
      cause_s1_q <= {sleep_pin, watchdog_pin, brown_out_pin,
                     power_on_pin};
      cause_s2_q <= cause_s1_q;
   end

   ////////////////////////////////////////////////////////////////////
   // Registers and APB handshake.

   logic pready_q, pready_d;
   logic [31:0] prdata_q, prdata_d;
   logic ind_we_q, ind_we_d;
   logic [8:0] ind_waddr_q, ind_waddr_d;
   logic [7:0] ind_wdata_q, ind_wdata_d;
   logic [12:0] pc_q, pc_d;
   logic [7:0] status_q, status_d;
   logic [7:0] fsr_q, fsr_d;
   logic [7:0] core_interrupt_control_q, core_interrupt_control_d;
   logic [7:0] option_q, option_d;
   logic [7:0] tra_q, tra_d;
   logic [7:0] trb_q, trb_d;
   logic [7:0] trc_q, trc_d;
   logic [7:0] trd_q, trd_d;
   logic [7:0] tre_q, tre_d;
   logic [7:0] program_counter_high_latch_q, program_counter_high_latch_d;
   logic [7:0] peripheral_interrupt_enable_1_q, peripheral_interrupt_enable_1_d;
   logic [7:0] peripheral_interrupt_enable_2_q, peripheral_interrupt_enable_2_d;
   logic [7:0] reset_cause_flags_q, reset_cause_flags_d;
   logic [7:0] pr2_q, pr2_d;
   logic [7:0] sadd_q, sadd_d;
   logic [7:0] txs_q, txs_d;
   logic [7:0] brg_q, brg_d;
   logic [7:0] adc_q, adc_d;
   logic [8:0] dec;
   logic [7:0] rd;
   logic [7:0] wd;
   logic take;
   logic wr;
   logic power_rst;

   always_comb
   begin
      dec = resolve(paddr[10:2],
                    {status_q[ST_RP1], status_q[ST_RP0]});
      take = psel && penable && pready_q;
      wr = take && pwrite && dec[8];
      wd = pwdata[7:0];
      power_rst = cause_s2_q[CS_POWER] || cause_s2_q[CS_BROWN];
      rd = RST_ZERO;
      if (dec[8])
      begin
         case (dec[7:0])
            OFS_INDIRECT_DATA_PORT: rd = indirect_rdata;
            OFS_TIMER_PRESCALE_OPTIONS: rd = option_q;
            OFS_PROGRAM_COUNTER_LOW: rd = pc_q[7:0];
            OFS_CORE_STATUS_FLAGS: rd = status_q;
            OFS_INDIRECT_ADDRESS_POINTER: rd = fsr_q;
            OFS_PORT_A_DIRECTION: rd = tra_q & MSK_PORT_A_DIR;
            OFS_PORT_B_DIRECTION: rd = trb_q;
            OFS_PORT_C_DIRECTION: rd = trc_q;
            OFS_PORT_D_DIRECTION: rd = trd_q;
            OFS_PORT_E_DIRECTION: rd = (tre_q & MSK_PORT_E_DIR_W) |
               {psp_buffer_flags, 6'h00};
            OFS_PROGRAM_COUNTER_HIGH_LATCH: rd = program_counter_high_latch_q;
            OFS_CORE_INTERRUPT_CONTROL: rd = core_interrupt_control_q;
            OFS_PERIPHERAL_INT_ENABLE_1: rd = peripheral_interrupt_enable_1_q;
            OFS_PERIPHERAL_INT_ENABLE_2: rd = peripheral_interrupt_enable_2_q;
            OFS_RESET_CAUSE_FLAGS: rd = reset_cause_flags_q;
            OFS_TIMER2_PERIOD: rd = pr2_q;
            OFS_SERIAL_PORT_SLAVE_ADDRESS: rd = sadd_q;
            OFS_SERIAL_PORT_STATE: rd = {2'b00, serial_state};
            OFS_TRANSMITTER_CONTROL_STATE: rd = (txs_q & MSK_TRANSMITTER_CONTROL_STATE_W) |
               {6'h00, tx_shift_empty, 1'b0};
            OFS_BAUD_RATE_DIVISOR: rd = brg_q;
            OFS_ANALOG_PIN_CONFIG: rd = adc_q;
            default: rd = RST_ZERO;
         endcase
      end
      // One wait state: pready rises in the second access cycle.
      pready_d = psel && penable && !pready_q;
      prdata_d = pready_d ? {24'h000000, rd} : prdata_q;
      ind_we_d = 1'b0;
      ind_waddr_d = ind_waddr_q;
      ind_wdata_d = ind_wdata_q;
      pc_d = pc_q;
      status_d = status_q;
      fsr_d = fsr_q;
      core_interrupt_control_d = core_interrupt_control_q;
      option_d = option_q;
      tra_d = tra_q;
      trb_d = trb_q;
      trc_d = trc_q;
      trd_d = trd_q;
      tre_d = tre_q;
      program_counter_high_latch_d = program_counter_high_latch_q;
      peripheral_interrupt_enable_1_d = peripheral_interrupt_enable_1_q;
      peripheral_interrupt_enable_2_d = peripheral_interrupt_enable_2_q;
      reset_cause_flags_d = reset_cause_flags_q;
      pr2_d = pr2_q;
      sadd_d = sadd_q;
      txs_d = txs_q;
      brg_d = brg_q;
      adc_d = adc_q;
      if (wr)
      begin
         case (dec[7:0])
            OFS_INDIRECT_DATA_PORT:
            begin
               ind_we_d = 1'b1;
               ind_waddr_d = {status_q[ST_IRP], fsr_q};
               ind_wdata_d = wd;
            end
            OFS_TIMER_PRESCALE_OPTIONS: option_d = wd;
            OFS_PROGRAM_COUNTER_LOW: pc_d = {program_counter_high_latch_q[4:0], wd};
            // Time-out and power-down bits are read-only.
            OFS_CORE_STATUS_FLAGS: status_d =
               (wd & MSK_STATUS_W) | (status_q & ~MSK_STATUS_W);
            OFS_INDIRECT_ADDRESS_POINTER: fsr_d = wd;
            OFS_PORT_A_DIRECTION: tra_d = wd & MSK_PORT_A_DIR;
            OFS_PORT_B_DIRECTION: trb_d = wd;
            OFS_PORT_C_DIRECTION: trc_d = wd;
            OFS_PORT_D_DIRECTION: trd_d = wd;
            OFS_PORT_E_DIRECTION: tre_d = wd & MSK_PORT_E_DIR_W;
            OFS_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_d = wd & MSK_PC_LATCH;
            OFS_CORE_INTERRUPT_CONTROL: core_interrupt_control_d = wd;
            OFS_PERIPHERAL_INT_ENABLE_1: peripheral_interrupt_enable_1_d = wd;
            OFS_PERIPHERAL_INT_ENABLE_2: peripheral_interrupt_enable_2_d = wd & MSK_PERIPHERAL_INTERRUPT_ENABLE_2;
            OFS_RESET_CAUSE_FLAGS:
            begin
               reset_cause_flags_d[RESET_CAUSE_FLAGS_POR] = wd[RESET_CAUSE_FLAGS_POR];
               reset_cause_flags_d[RESET_CAUSE_FLAGS_BOR] = wd[RESET_CAUSE_FLAGS_BOR];
            end
            OFS_TIMER2_PERIOD: pr2_d = wd;
            OFS_SERIAL_PORT_SLAVE_ADDRESS: sadd_d = wd;
            OFS_TRANSMITTER_CONTROL_STATE: txs_d = wd & MSK_TRANSMITTER_CONTROL_STATE_W;
            OFS_BAUD_RATE_DIVISOR: brg_d = wd;
            OFS_ANALOG_PIN_CONFIG: adc_d = wd & MSK_ANALOG_CFG;
            default: ind_we_d = 1'b0;
         endcase
      end
      if (!rst_b)
      begin
         pready_d = 1'b0;
         prdata_d = 32'h00000000;
         ind_we_d = 1'b0;
         ind_waddr_d = 9'h000;
         ind_wdata_d = RST_ZERO;
         pc_d = 13'h0000;
         option_d = RST_OPTIONS;
         tra_d = RST_PORT_A_DIR;
         trb_d = RST_PORT_DIR;
         trc_d = RST_PORT_DIR;
         trd_d = RST_PORT_DIR;
         tre_d = RST_PORT_E_DIR;
         program_counter_high_latch_d = RST_ZERO;
         peripheral_interrupt_enable_1_d = RST_ZERO;
         peripheral_interrupt_enable_2_d = RST_ZERO;
         pr2_d = RST_TIMER2_PERIOD;
         sadd_d = RST_ZERO;
         txs_d = RST_ZERO;
         brg_d = RST_ZERO;
         adc_d = RST_ZERO;
         if (power_rst)
         begin
            // Unknown bits are given zero for repeatability.
            status_d = RST_STATUS_POWER;
            fsr_d = RST_ZERO;
            core_interrupt_control_d = RST_ZERO;
         end
         else
         begin
            status_d = {3'b000, !cause_s2_q[CS_WDOG],
                        !cause_s2_q[CS_SLEEP], status_q[2:0]};
            core_interrupt_control_d = {7'h00, core_interrupt_control_q[CORE_INTERRUPT_CONTROL_RBIF]};
         end
         if (cause_s2_q[CS_POWER])
         begin
            reset_cause_flags_d[RESET_CAUSE_FLAGS_POR] = 1'b0;
            reset_cause_flags_d[RESET_CAUSE_FLAGS_BOR] = 1'b1;
         end
         else if (cause_s2_q[CS_BROWN])
         begin
            reset_cause_flags_d[RESET_CAUSE_FLAGS_POR] = 1'b1;
            reset_cause_flags_d[RESET_CAUSE_FLAGS_BOR] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      ind_we_q <= ind_we_d;
      ind_waddr_q <= ind_waddr_d;
      ind_wdata_q <= ind_wdata_d;
      pc_q <= pc_d;
      status_q <= status_d;
      fsr_q <= fsr_d;
      core_interrupt_control_q <= core_interrupt_control_d;
      option_q <= option_d;
      tra_q <= tra_d;
      trb_q <= trb_d;
      trc_q <= trc_d;
      trd_q <= trd_d;
      tre_q <= tre_d;
      program_counter_high_latch_q <= program_counter_high_latch_d;
      peripheral_interrupt_enable_1_q <= peripheral_interrupt_enable_1_d;
      peripheral_interrupt_enable_2_q <= peripheral_interrupt_enable_2_d;
      reset_cause_flags_q <= {6'h00, reset_cause_flags_d[1:0]};
      pr2_q <= pr2_d;
      sadd_q <= sadd_d;
      txs_q <= txs_d;
      brg_q <= brg_d;
      adc_q <= adc_d;
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs.

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign indirect_we = ind_we_q;
   assign indirect_waddr = ind_waddr_q;
   assign indirect_wdata = ind_wdata_q;
   assign program_counter = pc_q;
   assign core_status_flags = status_q;
   assign indirect_address_pointer = fsr_q;
   assign core_interrupt_control = core_interrupt_control_q;
   assign timer_prescale_options = option_q;
   assign port_a_direction = tra_q;
   assign port_b_direction = trb_q;
   assign port_c_direction = trc_q;
   assign port_d_direction = trd_q;
   assign port_e_direction = tre_q;
   assign peripheral_int_enable_1 = peripheral_interrupt_enable_1_q;
   assign peripheral_int_enable_2 = peripheral_interrupt_enable_2_q;
   assign reset_cause_flags = reset_cause_flags_q;
   assign timer2_period = pr2_q;
   assign serial_port_slave_address = sadd_q;
   assign transmitter_control = txs_q;
   assign baud_rate_divisor = brg_q;
   assign analog_pin_config = adc_q;

endmodule
`default_nettype wire

// ---- bsr_pkg.sv ----
/*
 Constants for the second special register bank: register indices,
 reset values, implemented-bit masks and bit positions.
 Assumes nothing of its surroundings; included by the bank module only.
*/
`default_nettype none
package bsr_pkg;
   // Register indices; the APB byte address is four times the index.
   localparam logic [7:0] OFS_INDIRECT_DATA_PORT = 8'h80;
   localparam logic [7:0] OFS_TIMER_PRESCALE_OPTIONS = 8'h81;
   localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW = 8'h82;
   localparam logic [7:0] OFS_CORE_STATUS_FLAGS = 8'h83;
   localparam logic [7:0] OFS_INDIRECT_ADDRESS_POINTER = 8'h84;
   localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h85;
   localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h86;
   localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h87;
   localparam logic [7:0] OFS_PORT_D_DIRECTION = 8'h88;
   localparam logic [7:0] OFS_PORT_E_DIRECTION = 8'h89;
   localparam logic [7:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 8'h8a;
   localparam logic [7:0] OFS_CORE_INTERRUPT_CONTROL = 8'h8b;
   localparam logic [7:0] OFS_PERIPHERAL_INT_ENABLE_1 = 8'h8c;
   localparam logic [7:0] OFS_PERIPHERAL_INT_ENABLE_2 = 8'h8d;
   localparam logic [7:0] OFS_RESET_CAUSE_FLAGS = 8'h8e;
   localparam logic [7:0] OFS_TIMER2_PERIOD = 8'h92;
   localparam logic [7:0] OFS_SERIAL_PORT_SLAVE_ADDRESS = 8'h93;
   localparam logic [7:0] OFS_SERIAL_PORT_STATE = 8'h94;
   localparam logic [7:0] OFS_TRANSMITTER_CONTROL_STATE = 8'h98;
   localparam logic [7:0] OFS_BAUD_RATE_DIVISOR = 8'h99;
   localparam logic [7:0] OFS_ANALOG_PIN_CONFIG = 8'h9f;
   // Index bit that selects the direct, bank-select-resolved window.
   localparam int IDX_DIRECT_BIT = 8;
   localparam logic [1:0] BANK_ZERO = 2'b00;
   localparam logic [1:0] BANK_ONE = 2'b01;
   // Reset values.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_OPTIONS = 8'hff;
   localparam logic [7:0] RST_PORT_A_DIR = 8'h3f;
   localparam logic [7:0] RST_PORT_DIR = 8'hff;
   localparam logic [7:0] RST_PORT_E_DIR = 8'h07;
   localparam logic [7:0] RST_TIMER2_PERIOD = 8'hff;
   localparam logic [7:0] RST_STATUS_POWER = 8'h18;
   // Implemented and writable bit masks.
   localparam logic [7:0] MSK_PORT_A_DIR = 8'h3f;
   localparam logic [7:0] MSK_PORT_E_DIR_W = 8'h37;
   localparam logic [7:0] MSK_PC_LATCH = 8'h1f;
   localparam logic [7:0] MSK_PERIPHERAL_INTERRUPT_ENABLE_2 = 8'h01;
   localparam logic [7:0] MSK_STATUS_W = 8'he7;
   localparam logic [7:0] MSK_TRANSMITTER_CONTROL_STATE_W = 8'hf5;
   localparam logic [7:0] MSK_ANALOG_CFG = 8'h07;
   localparam logic [7:0] MSK_SSP_STATE = 8'h3f;
   // Bit positions.
   localparam int ST_IRP = 7;
   localparam int ST_RP1 = 6;
   localparam int ST_RP0 = 5;
   localparam int ST_TO = 4;
   localparam int ST_PD = 3;
   localparam int RESET_CAUSE_FLAGS_POR = 1;
   localparam int RESET_CAUSE_FLAGS_BOR = 0;
   localparam int TRANSMITTER_CONTROL_STATE_TRMT = 1;
   localparam int PORT_E_DIRECTION_PSP_STATUS_IBF = 7;
   localparam int PORT_E_DIRECTION_PSP_STATUS_OBF = 6;
   localparam int CORE_INTERRUPT_CONTROL_RBIF = 0;
   // Reset cause pin positions.
   localparam int CS_POWER = 0;
   localparam int CS_BROWN = 1;
   localparam int CS_WDOG = 2;
   localparam int CS_SLEEP = 3;
endpackage
`default_nettype wire

// ---- bsr_bank_chk.sv ----
/*
 Checker for the second special register bank: read zeros, aliases,
 program counter load, indirect write pulse and reset columns.
 Assumes it is bound to bsr_bank and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module bsr_bank_chk
#(
   parameter int P_ADDR_W = 11
)
(
   // Clock, reset and APB.
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [P_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // Reset causes.
   input wire logic power_on_pin,
   input wire logic brown_out_pin,
   input wire logic watchdog_pin,
   // Register and core side.
   input wire logic indirect_we,
   input wire logic [8:0] indirect_waddr,
   input wire logic [7:0] indirect_wdata,
   input wire logic [12:0] program_counter,
   input wire logic [7:0] core_status_flags,
   input wire logic [7:0] indirect_address_pointer,
   input wire logic [7:0] reset_cause_flags,
   input wire logic [7:0] port_a_direction
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   logic [8:0] idx;
   logic done, wr, wr_ind;
   logic [15:0] ind_d, ind_q;
   assign idx = paddr[P_ADDR_W-1:2];
   assign done = psel && penable && pready;
   assign wr = done && pwrite;
   assign wr_ind = wr && (idx == 9'h080 || idx == 9'h000 || idx == 9'h100);
   // The pointer is captured with the data because a later write may move it.
   assign ind_d = wr_ind ? {indirect_address_pointer, pwdata[7:0]} : ind_q;
   always_ff @(posedge clk_sys)
      ind_q <= ind_d;
   ////////////////////////////////////////
   chk_ready_wait: assert property ((psel && !penable ##1 psel && penable)
      |-> !pready ##1 pready) else $error("wait state not one cycle");
   chk_upper_zero: assert property (prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_unmapped_zero: assert property (done && !pwrite && idx inside
      {[9'h08f:9'h091], [9'h095:9'h097], [9'h09a:9'h09e]} |-> prdata == 0)
      else $error("unmapped read not zero");
   chk_unmapped_wr: assert property (wr && idx == 9'h08f |=>
      $stable(port_a_direction) && $stable(core_status_flags))
      else $error("unmapped write changed a register");
   chk_status_alias: assert property (wr && idx[6:0] == 7'h03 &&
      !idx[8] |=> core_status_flags[2:0] == $past(pwdata[2:0]))
      else $error("status alias write lost");
   chk_bank_one: assert property (wr && idx == 9'h105 &&
      core_status_flags[6:5] == 2'b01 |=>
      port_a_direction[5:0] == $past(pwdata[5:0]))
      else $error("direct bank one write lost");
   chk_pc_load: assert property (wr && idx == 9'h082 |=>
      program_counter[7:0] == $past(pwdata[7:0]))
      else $error("program counter low not loaded");
   chk_ind_write: assert property (wr_ind |=> ##[0:1] (indirect_we &&
      {indirect_waddr[7:0], indirect_wdata} == ind_q))
      else $error("indirect write missing or wrong");
   chk_ind_only: assert property (indirect_we |->
      $past(wr_ind) || $past(wr_ind, 2)) else $error("stray indirect write");
   chk_power_reset: assert property ($rose(rst_b) &&
      $past(power_on_pin) |-> core_status_flags == 8'h18 &&
      reset_cause_flags[1:0] == 2'b01 && indirect_address_pointer == 0)
      else $error("power reset values wrong");
   chk_other_reset: assert property ($rose(rst_b) &&
      !$past(power_on_pin) && !$past(brown_out_pin) |->
      core_status_flags[7:4] == {3'b000, !$past(watchdog_pin)})
      else $error("other reset status wrong");
   cover property (wr_ind);
   cover property (done && !pwrite && idx == 9'h08f);
   cover property ($rose(rst_b) && !$past(power_on_pin));
endmodule
bind bsr_bank bsr_bank_chk #(.P_ADDR_W(P_ADDR_W)) u_chk (.clk_sys, .rst_b,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .power_on_pin, .brown_out_pin, .watchdog_pin, .indirect_we,
   .indirect_waddr, .indirect_wdata, .program_counter, .core_status_flags,
   .indirect_address_pointer, .reset_cause_flags, .port_a_direction);
`default_nettype wire

// ---- tb_bsr_bank.sv ----
/*
 Self-checking bench for the second special register bank over APB.
 Assumes bsr_pkg, bsr_bank and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_bsr_bank;
   logic clk_sys, rst_b, psel, penable, pwrite, pready, indirect_we;
   logic power_on_pin, brown_out_pin, watchdog_pin, sleep_pin;
   logic tx_shift_empty;
   logic [10:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] psp_buffer_flags;
   logic [5:0] serial_state;
   logic [7:0] indirect_rdata, indirect_wdata;
   logic [8:0] indirect_waddr;
   logic [12:0] program_counter;
   logic [7:0] o_sta, o_fsr, o_int, o_opt, o_tra, o_trb, o_trc, o_trd;
   logic [7:0] o_tre, o_ie1, o_ie2, o_pcn, o_pr2, o_sad, o_txc, o_brg, o_adc;
   int n_fail, num_checks;
   bsr_bank #(.P_ADDR_W(11)) DUT
   (
      .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .power_on_pin, .brown_out_pin, .watchdog_pin, .sleep_pin,
      .psp_buffer_flags, .tx_shift_empty, .serial_state, .indirect_rdata,
      .indirect_we, .indirect_waddr, .indirect_wdata, .program_counter,
      .core_status_flags(o_sta), .indirect_address_pointer(o_fsr),
      .core_interrupt_control(o_int), .timer_prescale_options(o_opt),
      .port_a_direction(o_tra), .port_b_direction(o_trb),
      .port_c_direction(o_trc), .port_d_direction(o_trd),
      .port_e_direction(o_tre), .peripheral_int_enable_1(o_ie1),
      .peripheral_int_enable_2(o_ie2), .reset_cause_flags(o_pcn),
      .timer2_period(o_pr2), .serial_port_slave_address(o_sad),
      .transmitter_control(o_txc), .baud_rate_divisor(o_brg),
      .analog_pin_config(o_adc)
   );
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [8:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         n_fail++;
         $display("[FAIL] t=%0t no ready", $time);
      end
      rd = prdata[7:0];
      `CHK(prdata[31:8], 24'h000000)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      logic [7:0] r;
      apb(1'b1, idx, d, r);
   endtask
   // Outputs hold stored bits only; psp_buffer_flags and tx_shift_empty are merged here.
   function automatic logic [8:0] out_of(input logic [8:0] i);
      case (i)
         9'h081: out_of = {1'b1, o_opt};
         9'h082: out_of = {1'b1, program_counter[7:0]};
         9'h083: out_of = {1'b1, o_sta};
         9'h084: out_of = {1'b1, o_fsr};
         9'h085: out_of = {1'b1, o_tra};
         9'h086: out_of = {1'b1, o_trb};
         9'h087: out_of = {1'b1, o_trc};
         9'h088: out_of = {1'b1, o_trd};
         9'h089: out_of = {1'b1, o_tre | {psp_buffer_flags, 6'h00}};
         9'h08b: out_of = {1'b1, o_int};
         9'h08c: out_of = {1'b1, o_ie1};
         9'h08d: out_of = {1'b1, o_ie2};
         9'h08e: out_of = {1'b1, o_pcn};
         9'h092: out_of = {1'b1, o_pr2};
         9'h093: out_of = {1'b1, o_sad};
         9'h098: out_of = {1'b1, o_txc | {6'h00, tx_shift_empty, 1'b0}};
         9'h099: out_of = {1'b1, o_brg};
         9'h09f: out_of = {1'b1, o_adc};
         default: out_of = 9'h000;
      endcase
   endfunction
   task automatic rd_chk(input logic [8:0] idx, input logic [7:0] e);
      logic [7:0] r;
      logic [8:0] o;
      apb(1'b0, idx, 8'h00, r);
      `CHK(r, e)
      o = out_of(idx);
      if (o[8])
         `CHK(o[7:0], e)
   endtask
   // Cause pins settle three cycles before reset, as the synchroniser needs.
   task automatic do_reset(input logic [3:0] c);
      @(posedge clk_sys);
      {sleep_pin, watchdog_pin, brown_out_pin, power_on_pin} <= c;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
   endtask
   task automatic ind_chk(input logic [8:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      wr(idx, d);
      #1;
      while (indirect_we !== 1'b1 && n < 3)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      `CHK(indirect_we, 1'b1)
      `CHK(indirect_waddr, 9'h03c)
      `CHK(indirect_wdata, d)
   endtask
   function automatic logic [7:0] exp_val(input logic [7:0] i, input logic f);
      case (i)
         8'h81, 8'h86, 8'h87, 8'h88, 8'h92: exp_val = 8'hff;
         8'h82, 8'h84, 8'h8b, 8'h8c, 8'h93, 8'h99: exp_val = {8{f}};
         8'h83: exp_val = 8'h18;
         8'h85: exp_val = 8'h3f;
         8'h89: exp_val = (f ? 8'h37 : 8'h07) | {psp_buffer_flags, 6'h00};
         8'h8a: exp_val = f ? 8'h1f : 8'h00;
         8'h8d: exp_val = {7'h00, f};
         8'h8e: exp_val = 8'h01;
         8'h94: exp_val = {2'b00, serial_state};
         8'h98: exp_val = (f ? 8'hf5 : 8'h00) | 8'h02;
         8'h9f: exp_val = f ? 8'h07 : 8'h00;
         default: exp_val = 8'h00;
      endcase
   endfunction
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {sleep_pin, watchdog_pin, brown_out_pin, power_on_pin} = 4'b0001;
      psp_buffer_flags = 2'b01;
      tx_shift_empty = 1'b1;
      serial_state = 6'h2a;
      indirect_rdata = 8'h5a;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 8'h81; i <= 8'h9f; i++)
         rd_chk(9'(i), exp_val(8'(i), 1'b0));
      for (int i = 8'h81; i <= 8'h9f; i++)
         if (i != 8'h83 && i != 8'h8e)
            wr(9'(i), 8'hff);
      for (int i = 8'h81; i <= 8'h9f; i++)
         rd_chk(9'(i), exp_val(8'(i), 1'b1));
      wr(9'h088, 8'h00);
      wr(9'h089, 8'h00);
      wr(9'h09f, 8'h00);
      rd_chk(9'h088, 8'h00);
      rd_chk(9'h089, 8'h40);
      rd_chk(9'h09f, 8'h00);
      wr(9'h003, 8'h20);
      wr(9'h105, 8'h15);
      rd_chk(9'h085, 8'h15);
      wr(9'h083, 8'h00);
      wr(9'h105, 8'h2a);
      rd_chk(9'h085, 8'h15);
      wr(9'h10b, 8'h81);
      rd_chk(9'h08b, 8'h81);
      wr(9'h08a, 8'hf3);
      wr(9'h082, 8'h7c);
      #1;
      `CHK(program_counter, 13'h137c)
      wr(9'h084, 8'h3c);
      ind_chk(9'h080, 8'ha5);
      ind_chk(9'h100, 8'h66);
      rd_chk(9'h080, 8'h5a);
      wr(9'h083, 8'h05);
      wr(9'h08b, 8'hff);
      do_reset(4'b0100);
      rd_chk(9'h083, 8'h0d);
      rd_chk(9'h084, 8'h3c);
      rd_chk(9'h08b, 8'h01);
      rd_chk(9'h08e, 8'h01);
      rd_chk(9'h085, 8'h3f);
      do_reset(4'b1000);
      rd_chk(9'h083, 8'h15);
      do_reset(4'b0010);
      rd_chk(9'h083, 8'h18);
      rd_chk(9'h08e, 8'h02);
      do_reset(4'b0001);
      rd_chk(9'h08e, 8'h01);
      rd_chk(9'h084, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
